/* File: supply_monitor_control.sv */
`timescale 1ns/1ps
`include "smc_defs.svh"

module supply_monitor_control (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] io_addr_in,
  input wire logic extended_io_bank_flag_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic power_down_in,
  input wire logic low_speed_osc_in,
  input wire logic precision_reset_comparator_in,
  input wire logic low_voltage_comparator_in,
  output logic [7:0] io_rdata_out,
  output logic [1:0] reset_level_select_out,
  output logic [2:0] detect_threshold_select_out,
  output logic precision_reset_out,
  output logic monitor_enable_out,
  output logic cpu_resume_ready_out
);

  // Pin synchronisers: bit 0 slow osc, bit 1 reset comparator, bit 2 detect comparator
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] stable_reg;
  logic [2:0] stable_next;
  logic slow_tick;

  // Register file and sequencing state
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [7:0] duty_reg;
  logic [7:0] duty_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  smc_pkg::smc_state_t state_reg;
  smc_pkg::smc_state_t state_next;
  logic [8:0] duty_cnt_reg;
  logic [8:0] duty_cnt_next;
  logic [8:0] duty_period;
  logic monitor_on_reg;
  logic monitor_on_next;
  logic resume_reg;
  logic resume_next;
  logic preset_reg;
  logic preset_next;
  logic [1:0] level_out_reg;
  logic [1:0] level_out_next;
  logic [8:0] full_addr;
  logic hit_config;
  logic hit_status;
  logic hit_duty;
  logic [1:0] reset_level;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      stable_reg <= 3'h0;
    end else begin
      sync1_reg <= {low_voltage_comparator_in, precision_reset_comparator_in,
                    low_speed_osc_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= stable_next;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      stable_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : stable_reg[i];
    end
  end

  // One-cycle enable on each rising edge of the slow oscillator
  assign slow_tick = stable_next[0] & ~stable_reg[0];

  // Bank bit joins the low address, so a clear flag never hits
  assign full_addr = {extended_io_bank_flag_in, io_addr_in};
  assign hit_config = (full_addr == `SMC_ADDR_THRESHOLD_CONFIG);
  assign hit_status = (full_addr == `SMC_ADDR_COMPARATOR_STATUS);
  assign hit_duty = (full_addr == `SMC_ADDR_DUTY_TRIM);
  assign reset_level = config_reg[`SMC_RESET_LEVEL_MSB:`SMC_RESET_LEVEL_LSB];

  // Sleep period length from the duty field
  always_comb begin
    unique case (smc_pkg::smc_duty_t'(duty_reg[`SMC_DUTY_MSB:`SMC_DUTY_LSB]))
      smc_pkg::SMC_DUTY_1_128: duty_period = `SMC_DUTY_PERIOD_128;
      smc_pkg::SMC_DUTY_1_512: duty_period = `SMC_DUTY_PERIOD_512;
      smc_pkg::SMC_DUTY_1_32: duty_period = `SMC_DUTY_PERIOD_32;
      smc_pkg::SMC_DUTY_1_8: duty_period = `SMC_DUTY_PERIOD_8;
    endcase
  end

  // Register writes; status has no write path, reserved bits masked off
  always_comb begin
    config_next = config_reg;
    duty_next = duty_reg;
    if (io_wr_in && hit_config) begin
      config_next = io_wdata_in & `SMC_CONFIG_WMASK;
    end
    if (io_wr_in && hit_duty) begin
      duty_next = io_wdata_in & `SMC_DUTY_WMASK;
    end
  end

  // Reads answer one cycle later; misses and idle cycles read zero
  always_comb begin
    rdata_next = 8'h00;
    if (io_rd_in) begin
      if (hit_config) begin
        rdata_next = config_reg;
      end else if (hit_status) begin
        rdata_next = {6'h00, status_reg};
      end else if (hit_duty) begin
        rdata_next = duty_reg;
      end
    end
  end

  // Analog threshold code: the no-reset code still compares at the 3 V range
  always_comb begin
    level_out_next = reset_level;
    if (reset_level == `SMC_LEVEL_NO_RESET) begin
      level_out_next = `SMC_LEVEL_3V0;
    end
  end

  // Sleep sequencing, duty-cycled sampling and wake-up sample
  always_comb begin
    state_next = state_reg;
    duty_cnt_next = duty_cnt_reg;
    monitor_on_next = monitor_on_reg;
    status_next = status_reg;
    resume_next = resume_reg;
    unique case (state_reg)
      smc_pkg::SMC_AWAKE: begin
        // Live comparator state, no latching
        status_next = {stable_next[2], stable_next[1]};
        monitor_on_next = 1'b1;
        resume_next = 1'b1;
        duty_cnt_next = 9'h000;
        if (power_down_in) begin
          state_next = smc_pkg::SMC_ASLEEP;
          resume_next = 1'b0;
        end
      end
      smc_pkg::SMC_ASLEEP: begin
        // Status follows comparators only inside the on window
        if (monitor_on_reg) begin
          status_next = {stable_next[2], stable_next[1]};
        end
        if (slow_tick) begin
          if (duty_cnt_reg >= duty_period) begin
            duty_cnt_next = 9'h000;
            monitor_on_next = 1'b1;
          end else begin
            duty_cnt_next = duty_cnt_reg + 9'h001;
            monitor_on_next = 1'b0;
          end
        end
        if (!power_down_in) begin
          state_next = smc_pkg::SMC_WAKE_SETTLE;
          monitor_on_next = 1'b1;
        end
      end
      smc_pkg::SMC_WAKE_SETTLE: begin
        // Settled values taken on the slow edge before the CPU may go
        if (slow_tick) begin
          status_next = {stable_next[2], stable_next[1]};
          state_next = smc_pkg::SMC_AWAKE;
          resume_next = 1'b1;
        end
      end
    endcase
  end

  // Reset output held by the tripped comparator unless suppressed
  always_comb begin
    preset_next = status_next[`SMC_STATUS_RESET_BIT] &&
                  (reset_level != `SMC_LEVEL_NO_RESET);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      config_reg <= `SMC_CONFIG_RESET;
      duty_reg <= `SMC_DUTY_RESET;
      status_reg <= 2'h0;
      rdata_reg <= 8'h00;
      state_reg <= smc_pkg::SMC_AWAKE;
      duty_cnt_reg <= 9'h000;
      monitor_on_reg <= 1'b1;
      resume_reg <= 1'b1;
      preset_reg <= 1'b0;
      level_out_reg <= `SMC_LEVEL_2V7;
    end else begin
      config_reg <= config_next;
      duty_reg <= duty_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      duty_cnt_reg <= duty_cnt_next;
      monitor_on_reg <= monitor_on_next;
      resume_reg <= resume_next;
      preset_reg <= preset_next;
      level_out_reg <= level_out_next;
    end
  end

  // All outputs straight from flip-flops
  assign io_rdata_out = rdata_reg;
  assign reset_level_select_out = level_out_reg;
  assign detect_threshold_select_out =
    config_reg[`SMC_DETECT_SEL_MSB:`SMC_DETECT_SEL_LSB];
  assign precision_reset_out = preset_reg;
  assign monitor_enable_out = monitor_on_reg;
  assign cpu_resume_ready_out = resume_reg;

endmodule

/* File: smc_defs.svh */
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Register addresses, bank flag in bit 8
`define SMC_ADDR_THRESHOLD_CONFIG 9'h1E3
`define SMC_ADDR_COMPARATOR_STATUS 9'h1E4
`define SMC_ADDR_DUTY_TRIM 9'h1EB

// Field positions
`define SMC_RESET_LEVEL_MSB 5
`define SMC_RESET_LEVEL_LSB 4
`define SMC_DETECT_SEL_MSB 2
`define SMC_DETECT_SEL_LSB 0
`define SMC_DUTY_MSB 7
`define SMC_DUTY_LSB 6
`define SMC_STATUS_DETECT_BIT 1
`define SMC_STATUS_RESET_BIT 0

// Writable bit masks
`define SMC_CONFIG_WMASK 8'h37
`define SMC_DUTY_WMASK 8'hC0

// Reset values
`define SMC_CONFIG_RESET 8'h00
`define SMC_STATUS_RESET 8'h00
`define SMC_DUTY_RESET 8'h00

// Reset level codes
`define SMC_LEVEL_2V7 2'h0
`define SMC_LEVEL_3V0 2'h1
`define SMC_LEVEL_5V0 2'h2
`define SMC_LEVEL_NO_RESET 2'h3

// Sleep period lengths minus one, in low-speed oscillator periods
`define SMC_DUTY_PERIOD_128 9'h07F
`define SMC_DUTY_PERIOD_512 9'h1FF
`define SMC_DUTY_PERIOD_32 9'h01F
`define SMC_DUTY_PERIOD_8 9'h007

`endif

/* File: smc_pkg.sv */
package smc_pkg;

  // Sleep sequencing of the monitor
  typedef enum logic [2:0] {
    SMC_AWAKE = 3'b001,
    SMC_ASLEEP = 3'b010,
    SMC_WAKE_SETTLE = 3'b100
  } smc_state_t;

  // Sleep duty-cycle codes
  typedef enum logic [1:0] {
    SMC_DUTY_1_128 = 2'h0,
    SMC_DUTY_1_512 = 2'h1,
    SMC_DUTY_1_32 = 2'h2,
    SMC_DUTY_1_8 = 2'h3
  } smc_duty_t;

endpackage

/* File: smc_monitor.sv */
`timescale 1ns/1ps
module smc_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] io_addr_in,
  input wire logic extended_io_bank_flag_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic power_down_in,
  input wire logic low_speed_osc_in,
  input wire logic precision_reset_comparator_in,
  input wire logic low_voltage_comparator_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic [1:0] reset_level_select_out,
  input wire logic [2:0] detect_threshold_select_out,
  input wire logic precision_reset_out,
  input wire logic monitor_enable_out,
  input wire logic cpu_resume_ready_out
);
  // Bank flag joins the address as bit 8
  logic [8:0] a;
  logic cw;
  assign a = {extended_io_bank_flag_in, io_addr_in};
  assign cw = io_wr_in && a == 9'h1E3;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence wr_duty; io_wr_in && a == 9'h1EB; endsequence
  sequence rd_duty; io_rd_in && a == 9'h1EB; endsequence
  rdata_idle_a: assert property (!io_rd_in |=> io_rdata_out == 8'h00)
    else $error("read data not idle");
  bank_refuse_a: assert property (io_rd_in && !a[8] |=> io_rdata_out == 8'h00)
    else $error("first bank read answered");
  // Threshold code is registered from the stored field, so it lands one cycle after config
  level_write_a: assert property (cw && io_wdata_in[5:4] != 2'h3
    |=> ##1 reset_level_select_out == $past(io_wdata_in[5:4], 2))
    else $error("level not taken");
  level_off_a: assert property (cw && io_wdata_in[5:4] == 2'h3
    |=> ##1 reset_level_select_out == 2'h1) else $error("code 11 not mapped to 3 V");
  detect_write_a: assert property (cw
    |=> detect_threshold_select_out == $past(io_wdata_in[2:0])) else $error("detect not taken");
  duty_readback_a: assert property (wr_duty ##1 rd_duty
    |=> io_rdata_out == ($past(io_wdata_in, 2) & 8'hC0)) else $error("duty readback wrong");
  reset_report_a: assert property (io_rd_in && a == 9'h1E4 && precision_reset_out
    |=> io_rdata_out[0]) else $error("reset comparator not reported");
  wake_monitor_a: assert property (!power_down_in && !cpu_resume_ready_out
    |=> monitor_enable_out) else $error("monitor off during wake");
endmodule

bind supply_monitor_control smc_monitor u_smc_monitor (.*);

/* File: test_supply_monitor_control.sv */
`timescale 1ns/1ps
module test_supply_monitor_control;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pd = 1'b0;
  logic osc = 1'b0;
  logic pc = 1'b0;
  logic lc = 1'b0;
  logic [7:0] rdat;
  logic [1:0] lvl;
  logic [2:0] det;
  logic prst;
  logic mon;
  logic res;
  int num_errors = 0;
  int cmp_count = 0;
  int oc = 0;
  int hi;
  int per[4] = '{32'h80, 32'h200, 32'h20, 32'h8};
  // Core clock
  always #5 clk_in = ~clk_in;
  // Slow tick every 20 core cycles keeps sleep runs short
  always @(posedge clk_in) begin
    oc <= (oc == 9) ? 0 : oc + 1;
    if (oc == 9) osc <= ~osc;
  end
  supply_monitor_control u_supply_monitor_control (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .io_addr_in(addr[7:0]),
    .extended_io_bank_flag_in(addr[8]), .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wd),
    .power_down_in(pd), .low_speed_osc_in(osc), .precision_reset_comparator_in(pc),
    .low_voltage_comparator_in(lc), .io_rdata_out(rdat), .reset_level_select_out(lvl),
    .detect_threshold_select_out(det), .precision_reset_out(prst),
    .monitor_enable_out(mon), .cpu_resume_ready_out(res)
  );
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single-byte write, strobe for one cycle
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data stands only one cycle, so it is checked mid-cycle
  task automatic rd_reg(input logic [8:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    cmp(rdat, e);
    @(posedge clk_in);
  endtask
  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    cmp({5'h00, mon, res, prst}, 8'h06);
    rd_reg(9'h1E3, 8'h00);
    rd_reg(9'h1E4, 8'h00);
    rd_reg(9'h1EB, 8'h00);
    // Every level and detect code, with reserved bits set
    for (int i = 0; i < 8; i++) begin
      wr_reg(9'h1E3, {2'h3, i[1:0], 1'b1, i[2:0]});
      rd_reg(9'h1E3, {2'h0, i[1:0], 1'b0, i[2:0]});
      cmp({3'h0, lvl, det}, {3'h0, (i[1:0] == 2'h3) ? 2'h1 : i[1:0], i[2:0]});
    end
    wr_reg(9'h0E3, 8'h00);
    rd_reg(9'h1E3, 8'h37);
    rd_reg(9'h0E3, 8'h00);
    rd_reg(9'h1E5, 8'h00);
    wr_reg(9'h1E4, 8'hFF);
    rd_reg(9'h1E4, 8'h00);
    // Comparators need a few edges to pass the synchronisers
    pc <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd_reg(9'h1E4, 8'h01);
    cmp({7'h00, prst}, 8'h00);
    wr_reg(9'h1E3, 8'h20);
    repeat (2) @(posedge clk_in);
    cmp({7'h00, prst}, 8'h01);
    rd_reg(9'h1E4, 8'h01);
    pc <= 1'b0;
    lc <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd_reg(9'h1E4, 8'h02);
    cmp({7'h00, prst}, 8'h00);
    lc <= 1'b0;
    // Over one full period the monitor is on for exactly one tick
    for (int i = 0; i < 4; i++) begin
      wr_reg(9'h1EB, {i[1:0], 6'h3F});
      rd_reg(9'h1EB, {i[1:0], 6'h00});
      pd <= 1'b1;
      repeat (per[i] * 20 + 40) @(posedge clk_in);
      cmp({7'h00, res}, 8'h00);
      hi = 0;
      repeat (per[i] * 20) begin
        @(posedge clk_in);
        hi += mon;
      end
      cmp(hi[7:0], 8'h14);
      pd <= 1'b0;
      repeat (30) @(posedge clk_in);
      cmp({6'h00, mon, res}, 8'h03);
    end
    final_report;
  end
  // Hang guard, about twice the expected run
  initial begin
    #600000;
    num_errors++;
    final_report;
  end
endmodule
